// ---- hw/psm_regs.vh ----
// Command codes, reset values and field positions of the status, telemetry and configuration bank.
`ifndef PSM_REGS_VH
`define PSM_REGS_VH
`define PSM_CMD_INPUT_STATUS        8'h7C
`define PSM_CMD_TEMPERATURE_STATUS  8'h7D
`define PSM_CMD_COMM_MEMORY_STATUS  8'h7E
`define PSM_CMD_VENDOR_STATE_STATUS 8'h80
`define PSM_CMD_INPUT_VOLTAGE       8'h88
`define PSM_CMD_OUTPUT_VOLTAGE      8'h8B
`define PSM_CMD_DIE_TEMPERATURE     8'h8D
`define PSM_CMD_PROTOCOL_REVISION   8'h98
`define PSM_CMD_CHANNEL_CONFIG      8'hD0
`define PSM_CMD_GLOBAL_CONFIG       8'hD1
`define PSM_CMD_PAIR0_PROPAGATE     8'hD2
`define PSM_CMD_PAIR1_PROPAGATE     8'hD3
`define PSM_CMD_SUPPLY_GOOD_MAP     8'hD4
`define PSM_CMD_FAULT_A_RESPONSE    8'hD5
`define PSM_CMD_FAULT_B_RESPONSE    8'hD6
`define PSM_CMD_FAULT_C_RESPONSE    8'hD7
`define PSM_CMD_FAULT_D_RESPONSE    8'hD8
`define PSM_CMD_ENABLE_OV_RESPONSE  8'hD9
`define PSM_CMD_ENABLE_UV_RESPONSE  8'hDA
`define PSM_CMD_RETRY_INTERVAL      8'hDB
`define PSM_CMD_RESTART_DELAY       8'hDC
`define PSM_CMD_OUTPUT_MAXIMUM      8'hDD
`define PSM_CMD_INPUT_MAXIMUM       8'hDE
`define PSM_CMD_TEMPERATURE_MAXIMUM 8'hDF
`define PSM_RST_CHANNEL_CONFIG      16'h0080
`define PSM_RST_GLOBAL_CONFIG       8'h7B
`define PSM_RST_BYTE_ZERO           8'h00
`define PSM_RST_WORD_ZERO           16'h0000
`define PSM_RST_RETRY_INTERVAL      16'hF320
`define PSM_RST_RESTART_DELAY       16'hFB20
`define PSM_LIN11_EXP_MSB           15
`define PSM_LIN11_EXP_LSB           11
`define PSM_LIN11_MANT_MSB          10
`define PSM_CML_INVALID_CMD_BIT     7
`define PSM_CML_INVALID_DATA_BIT    6
`define PSM_PEAK_FLOOR_LIN11        16'h8000
`define PSM_PEAK_FLOOR_LIN16        16'h0000
`define PSM_TICK_PERIOD_NS          1000000
`define PSM_CLK_PERIOD_NS           50
`endif

// ---- hw/psm_lin11_cmp.v ----
// Compares two linear eleven bit format words by value.
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.vh"
module psm_lin11_cmp (
	input  wire [15:0] value_a,
	input  wire [15:0] value_b,
	output wire        a_greater
);
	wire signed [4:0]  exp_a;
	wire signed [4:0]  exp_b;
	wire signed [10:0] mant_a;
	wire signed [10:0] mant_b;
	wire signed [47:0] scaled_a;
	wire signed [47:0] scaled_b;
	assign exp_a    = value_a[`PSM_LIN11_EXP_MSB:`PSM_LIN11_EXP_LSB];
	assign exp_b    = value_b[`PSM_LIN11_EXP_MSB:`PSM_LIN11_EXP_LSB];
	assign mant_a   = value_a[`PSM_LIN11_MANT_MSB:0];
	assign mant_b   = value_b[`PSM_LIN11_MANT_MSB:0];
	// Flipping the exponent sign bit gives exponent plus sixteen, so no fraction bit is lost.
	assign scaled_a = {{37{mant_a[10]}}, mant_a} << {~exp_a[4], exp_a[3:0]};
	assign scaled_b = {{37{mant_b[10]}}, mant_b} << {~exp_b[4], exp_b[3:0]};
	assign a_greater = scaled_a > scaled_b;
endmodule
`default_nettype wire

// ---- hw/psm_chan_mem.v ----
// Small per-channel word memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module psm_chan_mem #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3,
	parameter [15:0] INIT = 16'h0000
) (
	input  wire             clk_sys,
	input  wire             reset_n,
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_addr,
	input  wire [WIDTH-1:0] wr_data,
	input  wire [AW-1:0]    rd_addr,
	output reg  [WIDTH-1:0] rd_data,
	output wire [WIDTH*DEPTH-1:0] all_data
);
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_word
			reg [WIDTH-1:0] word_reg;
			always @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n)
					word_reg <= INIT[WIDTH-1:0];
				else if (wr_en && wr_addr == i)
					word_reg <= wr_data;
			end
			assign all_data[i*WIDTH +: WIDTH] = word_reg;
		end
	endgenerate
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			rd_data <= {WIDTH{1'b0}};
		else
			rd_data <= all_data[rd_addr*WIDTH +: WIDTH];
	end
endmodule
`default_nettype wire

// ---- hw/psm_bank.v ----
// Command-addressed status, telemetry and configuration bank of an eight channel supply manager.
//
// Function
// - read-only input status byte at 0x7C
// - read-only temperature status byte at 0x7D
// - read-only communication/memory status byte at 0x7E
// - paged read-only vendor state byte 0x80
// - input voltage eleven bit word at 0x88
// - paged output voltage 0x8B, non-paged temperature 0x8D
// - read-only protocol revision byte at 0x98
// - paged channel config word 0xD0, reset 0x0080
// - global config byte 0xD1, reset 0x7B
// - paged 0xD2 routes faulted-off to pair0
// - paged 0xD3 routes faulted-off to pair1
// - 0xD4 maps good states onto supply-good pin
// - fault pin responses 0xD5 to 0xD8
// - 0xD9 enable-pin overvoltage response
// - 0xDA enable-pin undervoltage response
// - retry interval word 0xDB, default 200ms
// - restart delay word 0xDC, default 400ms
// - peak trackers at 0xDD, 0xDE, 0xDF
// - eleven bit linear is mantissa times power
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.vh"
module psm_bank #(
	parameter CHANNELS = 8,
	parameter PAGE_W   = 3,
	parameter [7:0] REVISION_CODE = 8'h5A,
	parameter TICK_CYCLES = `PSM_TICK_PERIOD_NS / `PSM_CLK_PERIOD_NS
) (
	input  wire                  clk_sys,
	input  wire                  reset_n,
	input  wire [PAGE_W-1:0]     page,
	input  wire                  cmd_valid,
	input  wire                  cmd_write,
	input  wire                  cmd_word,
	input  wire [7:0]            cmd_code,
	input  wire [15:0]           cmd_wdata,
	output reg  [15:0]           cmd_rdata,
	output reg                   cmd_ack,
	input  wire                  cml_clear,
	input  wire [7:0]            input_fault_flags,
	input  wire [7:0]            temperature_fault_flags,
	input  wire [7:0]            memory_fault_flags,
	input  wire [8*CHANNELS-1:0] vendor_state_flags,
	input  wire                  sample_valid,
	input  wire [15:0]           input_voltage_sample,
	input  wire [15:0]           die_temperature_sample,
	input  wire                  vout_valid,
	input  wire [PAGE_W-1:0]     vout_channel,
	input  wire [15:0]           vout_sample,
	input  wire [CHANNELS-1:0]   channel_faulted_off,
	input  wire [CHANNELS-1:0]   channel_power_good,
	input  wire                  watchdog_reset_pin,
	input  wire                  shared_fault_pin_a,
	input  wire                  shared_fault_pin_b,
	input  wire                  shared_fault_pin_c,
	input  wire                  shared_fault_pin_d,
	input  wire                  retry_start,
	input  wire                  run_request_pin,
	input  wire                  output_ov_fault,
	input  wire                  output_uv_fault,
	output reg                   shared_fault_pin_a_oe,
	output reg                   shared_fault_pin_b_oe,
	output reg                   shared_fault_pin_c_oe,
	output reg                   shared_fault_pin_d_oe,
	output reg                   supply_good_pin,
	output reg  [7:0]            fault_pin_action,
	output reg                   input_supply_enable_pin,
	output reg                   retry_due,
	output reg                   run_request_virtual,
	output wire [16*CHANNELS-1:0] channel_config_all,
	output reg  [7:0]            global_config_out
);
	// Pin synchronisers: first stage feeds only the second.
	reg  [6:0] pin_meta_reg;
	reg  [6:0] pin_sync_reg;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			// The run pin resets low so that leaving reset cannot fake a run edge.
			pin_meta_reg <= 7'h3F;
			pin_sync_reg <= 7'h3F;
		end else begin
			pin_meta_reg <= {run_request_pin, watchdog_reset_pin, shared_fault_pin_d,
				shared_fault_pin_c, shared_fault_pin_b, shared_fault_pin_a, 1'b1};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	wire [3:0] fault_pin_sync = pin_sync_reg[4:1];
	wire       watchdog_ok    = pin_sync_reg[5];
	wire       run_sync       = pin_sync_reg[6];

	wire wr = cmd_valid && cmd_write;
	wire rd = cmd_valid && !cmd_write;

	// Non-paged writable registers and the communication status byte.
	reg [7:0]  pair_prop_unused_reg;
	reg [15:0] supply_good_map_reg;
	reg [7:0]  fault_response_reg [0:3];
	reg [7:0]  enable_ov_response_reg;
	reg [7:0]  enable_uv_response_reg;
	reg [15:0] retry_interval_reg;
	reg [15:0] restart_delay_reg;
	reg [7:0]  cml_reg;
	integer k;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			global_config_out      <= `PSM_RST_GLOBAL_CONFIG;
			supply_good_map_reg    <= `PSM_RST_WORD_ZERO;
			enable_ov_response_reg <= `PSM_RST_BYTE_ZERO;
			enable_uv_response_reg <= `PSM_RST_BYTE_ZERO;
			retry_interval_reg     <= `PSM_RST_RETRY_INTERVAL;
			restart_delay_reg      <= `PSM_RST_RESTART_DELAY;
			for (k = 0; k < 4; k = k + 1)
				fault_response_reg[k] <= `PSM_RST_BYTE_ZERO;
		end else if (wr) begin
			case (cmd_code)
			`PSM_CMD_GLOBAL_CONFIG:     global_config_out      <= cmd_wdata[7:0];
			`PSM_CMD_SUPPLY_GOOD_MAP:   supply_good_map_reg    <= cmd_wdata;
			`PSM_CMD_FAULT_A_RESPONSE:  fault_response_reg[0]  <= cmd_wdata[7:0];
			`PSM_CMD_FAULT_B_RESPONSE:  fault_response_reg[1]  <= cmd_wdata[7:0];
			`PSM_CMD_FAULT_C_RESPONSE:  fault_response_reg[2]  <= cmd_wdata[7:0];
			`PSM_CMD_FAULT_D_RESPONSE:  fault_response_reg[3]  <= cmd_wdata[7:0];
			`PSM_CMD_ENABLE_OV_RESPONSE: enable_ov_response_reg <= cmd_wdata[7:0];
			`PSM_CMD_ENABLE_UV_RESPONSE: enable_uv_response_reg <= cmd_wdata[7:0];
			`PSM_CMD_RETRY_INTERVAL:    retry_interval_reg     <= cmd_wdata;
			`PSM_CMD_RESTART_DELAY:     restart_delay_reg      <= cmd_wdata;
			default: ;
			endcase
		end
	end

	// Paged config registers and the output peak tracker live in per-channel memories.
	wire [15:0] chan_cfg_rd;
	wire [15:0] prop0_rd;
	wire [15:0] prop1_rd;
	wire [15:0] vpeak_rd;
	wire [16*CHANNELS-1:0] prop0_all;
	wire [16*CHANNELS-1:0] prop1_all;
	wire [16*CHANNELS-1:0] vpeak_all;
	wire [15:0] vpeak_cur = vpeak_all[vout_channel*16 +: 16];
	psm_chan_mem #(.WIDTH(16), .DEPTH(CHANNELS), .AW(PAGE_W), .INIT(`PSM_RST_CHANNEL_CONFIG)) u_cfg (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.wr_en(wr && cmd_code == `PSM_CMD_CHANNEL_CONFIG), .wr_addr(page), .wr_data(cmd_wdata),
		.rd_addr(page), .rd_data(chan_cfg_rd), .all_data(channel_config_all));
	psm_chan_mem #(.WIDTH(16), .DEPTH(CHANNELS), .AW(PAGE_W), .INIT(`PSM_RST_WORD_ZERO)) u_prop0 (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.wr_en(wr && cmd_code == `PSM_CMD_PAIR0_PROPAGATE), .wr_addr(page),
		.wr_data({8'h00, cmd_wdata[7:0]}),
		.rd_addr(page), .rd_data(prop0_rd), .all_data(prop0_all));
	psm_chan_mem #(.WIDTH(16), .DEPTH(CHANNELS), .AW(PAGE_W), .INIT(`PSM_RST_WORD_ZERO)) u_prop1 (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.wr_en(wr && cmd_code == `PSM_CMD_PAIR1_PROPAGATE), .wr_addr(page),
		.wr_data({8'h00, cmd_wdata[7:0]}),
		.rd_addr(page), .rd_data(prop1_rd), .all_data(prop1_all));
	// output peak, unsigned sixteen bit linear.
	psm_chan_mem #(.WIDTH(16), .DEPTH(CHANNELS), .AW(PAGE_W), .INIT(`PSM_PEAK_FLOOR_LIN16)) u_vpeak (
		.clk_sys(clk_sys), .reset_n(reset_n),
		.wr_en(vout_valid && vout_sample > vpeak_cur), .wr_addr(vout_channel), .wr_data(vout_sample),
		.rd_addr(page), .rd_data(vpeak_rd), .all_data(vpeak_all));

	// Latest telemetry and non-paged peaks.
	reg  [15:0] vin_reg;
	reg  [15:0] temp_reg;
	reg  [15:0] vin_peak_reg;
	reg  [15:0] temp_peak_reg;
	reg  [16*CHANNELS-1:0] vout_reg;
	wire vin_higher;
	wire temp_higher;
	psm_lin11_cmp u_cmp_vin (.value_a(input_voltage_sample), .value_b(vin_peak_reg), .a_greater(vin_higher));
	psm_lin11_cmp u_cmp_tmp (.value_a(die_temperature_sample), .value_b(temp_peak_reg), .a_greater(temp_higher));
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vin_reg       <= `PSM_RST_WORD_ZERO;
			temp_reg      <= `PSM_RST_WORD_ZERO;
			vin_peak_reg  <= `PSM_PEAK_FLOOR_LIN11;
			temp_peak_reg <= `PSM_PEAK_FLOOR_LIN11;
			vout_reg      <= {16*CHANNELS{1'b0}};
		end else begin
			if (sample_valid) begin
				vin_reg  <= input_voltage_sample;
				temp_reg <= die_temperature_sample;
				if (vin_higher)
					vin_peak_reg <= input_voltage_sample;
				if (temp_higher)
					temp_peak_reg <= die_temperature_sample;
			end
			if (vout_valid)
				vout_reg[vout_channel*16 +: 16] <= vout_sample;
		end
	end

	// Read-only commands and unknown commands.
	reg is_ro;
	reg is_known;
	always @* begin
		is_ro = 1'b0;
		is_known = 1'b1;
		case (cmd_code)
		`PSM_CMD_INPUT_STATUS, `PSM_CMD_TEMPERATURE_STATUS, `PSM_CMD_COMM_MEMORY_STATUS,
		`PSM_CMD_VENDOR_STATE_STATUS, `PSM_CMD_INPUT_VOLTAGE, `PSM_CMD_OUTPUT_VOLTAGE,
		`PSM_CMD_DIE_TEMPERATURE, `PSM_CMD_PROTOCOL_REVISION, `PSM_CMD_OUTPUT_MAXIMUM,
		`PSM_CMD_INPUT_MAXIMUM, `PSM_CMD_TEMPERATURE_MAXIMUM: is_ro = 1'b1;
		`PSM_CMD_CHANNEL_CONFIG, `PSM_CMD_GLOBAL_CONFIG, `PSM_CMD_PAIR0_PROPAGATE,
		`PSM_CMD_PAIR1_PROPAGATE, `PSM_CMD_SUPPLY_GOOD_MAP, `PSM_CMD_FAULT_A_RESPONSE,
		`PSM_CMD_FAULT_B_RESPONSE, `PSM_CMD_FAULT_C_RESPONSE, `PSM_CMD_FAULT_D_RESPONSE,
		`PSM_CMD_ENABLE_OV_RESPONSE, `PSM_CMD_ENABLE_UV_RESPONSE, `PSM_CMD_RETRY_INTERVAL,
		`PSM_CMD_RESTART_DELAY: is_ro = 1'b0;
		default: is_known = 1'b0;
		endcase
	end

	// Communication status: hardware set wins over software clear.
	wire [7:0] cml_set = {wr && is_ro, cmd_valid && !is_known, 6'h00};
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cml_reg <= `PSM_RST_BYTE_ZERO;
		else
			cml_reg <= (cml_clear ? 8'h00 : cml_reg) | cml_set;
	end

	// Read path: data follows two cycles after the request, with the ack.
	reg        rd_pend_reg;
	reg [7:0]  rd_code_reg;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_pend_reg <= 1'b0;
			rd_code_reg <= 8'h00;
		end else begin
			rd_pend_reg <= rd;
			rd_code_reg <= cmd_code;
		end
	end
	reg [15:0] rdata_next;
	always @* begin
		case (rd_code_reg)
		`PSM_CMD_INPUT_STATUS:        rdata_next = {8'h00, input_fault_flags};
		`PSM_CMD_TEMPERATURE_STATUS:  rdata_next = {8'h00, temperature_fault_flags};
		`PSM_CMD_COMM_MEMORY_STATUS:  rdata_next = {8'h00, cml_reg | memory_fault_flags};
		`PSM_CMD_VENDOR_STATE_STATUS: rdata_next = {8'h00, vendor_state_flags[page*8 +: 8]};
		`PSM_CMD_INPUT_VOLTAGE:       rdata_next = vin_reg;
		`PSM_CMD_OUTPUT_VOLTAGE:      rdata_next = vout_reg[page*16 +: 16];
		`PSM_CMD_DIE_TEMPERATURE:     rdata_next = temp_reg;
		`PSM_CMD_PROTOCOL_REVISION:   rdata_next = {8'h00, REVISION_CODE};
		`PSM_CMD_CHANNEL_CONFIG:      rdata_next = chan_cfg_rd;
		`PSM_CMD_GLOBAL_CONFIG:       rdata_next = {8'h00, global_config_out};
		`PSM_CMD_PAIR0_PROPAGATE:     rdata_next = prop0_rd;
		`PSM_CMD_PAIR1_PROPAGATE:     rdata_next = prop1_rd;
		`PSM_CMD_SUPPLY_GOOD_MAP:     rdata_next = supply_good_map_reg;
		`PSM_CMD_FAULT_A_RESPONSE:    rdata_next = {8'h00, fault_response_reg[0]};
		`PSM_CMD_FAULT_B_RESPONSE:    rdata_next = {8'h00, fault_response_reg[1]};
		`PSM_CMD_FAULT_C_RESPONSE:    rdata_next = {8'h00, fault_response_reg[2]};
		`PSM_CMD_FAULT_D_RESPONSE:    rdata_next = {8'h00, fault_response_reg[3]};
		`PSM_CMD_ENABLE_OV_RESPONSE:  rdata_next = {8'h00, enable_ov_response_reg};
		`PSM_CMD_ENABLE_UV_RESPONSE:  rdata_next = {8'h00, enable_uv_response_reg};
		`PSM_CMD_RETRY_INTERVAL:      rdata_next = retry_interval_reg;
		`PSM_CMD_RESTART_DELAY:       rdata_next = restart_delay_reg;
		`PSM_CMD_OUTPUT_MAXIMUM:      rdata_next = vpeak_rd;
		`PSM_CMD_INPUT_MAXIMUM:       rdata_next = vin_peak_reg;
		`PSM_CMD_TEMPERATURE_MAXIMUM: rdata_next = temp_peak_reg;
		default:                      rdata_next = 16'hFFFF;
		endcase
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cmd_rdata <= 16'h0000;
			cmd_ack   <= 1'b0;
		end else begin
			cmd_ack   <= rd_pend_reg | wr;
			cmd_rdata <= rd_pend_reg ? rdata_next : cmd_rdata;
		end
	end

	// Fault pin drive, supply-good and enable pin.
	reg [CHANNELS-1:0] prop0_bits;
	reg [CHANNELS-1:0] prop1_bits;
	integer c;
	always @* begin
		for (c = 0; c < CHANNELS; c = c + 1) begin
			prop0_bits[c] = prop0_all[c*16] & channel_faulted_off[c];
			prop1_bits[c] = prop1_all[c*16] & channel_faulted_off[c];
		end
	end
	wire [CHANNELS-1:0] good_miss = supply_good_map_reg[CHANNELS-1:0] & ~channel_power_good;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shared_fault_pin_a_oe   <= 1'b0;
			shared_fault_pin_b_oe   <= 1'b0;
			shared_fault_pin_c_oe   <= 1'b0;
			shared_fault_pin_d_oe   <= 1'b0;
			supply_good_pin         <= 1'b0;
			fault_pin_action        <= 8'h00;
			input_supply_enable_pin <= 1'b1;
		end else begin
			shared_fault_pin_a_oe <= |prop0_bits;
			shared_fault_pin_c_oe <= |prop0_bits;
			shared_fault_pin_b_oe <= |prop1_bits;
			shared_fault_pin_d_oe <= |prop1_bits;
			supply_good_pin <= ~|good_miss & (watchdog_ok | ~supply_good_map_reg[15]);
			fault_pin_action <= (~fault_pin_sync[0] ? fault_response_reg[0] : 8'h00)
				| (~fault_pin_sync[1] ? fault_response_reg[1] : 8'h00)
				| (~fault_pin_sync[2] ? fault_response_reg[2] : 8'h00)
				| (~fault_pin_sync[3] ? fault_response_reg[3] : 8'h00);
			// enable pin pull-down on selected faults.
			if ((output_ov_fault && enable_ov_response_reg[7]) || (output_uv_fault && enable_uv_response_reg[7]))
				input_supply_enable_pin <= 1'b0;
		end
	end

	// Millisecond tick and delay timers.
	reg [31:0] tick_cnt_reg;
	wire       tick = (tick_cnt_reg == TICK_CYCLES - 1);
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			tick_cnt_reg <= 32'h0;
		else
			tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
	end
	function [15:0] lin11_ms;
		input [15:0] v;
		reg signed [4:0] e;
		reg [10:0] m;
		begin
			e = v[`PSM_LIN11_EXP_MSB:`PSM_LIN11_EXP_LSB];
			m = v[10] ? 11'h000 : v[`PSM_LIN11_MANT_MSB:0];
			lin11_ms = e[4] ? ({5'h00, m} >> (-e)) : ({5'h00, m} << e);
		end
	endfunction
	reg [15:0] retry_cnt_reg;
	reg [15:0] restart_cnt_reg;
	reg        retry_run_reg;
	reg        restart_run_reg;
	reg        run_prev_reg;
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			retry_cnt_reg       <= 16'h0;
			restart_cnt_reg     <= 16'h0;
			retry_run_reg       <= 1'b0;
			restart_run_reg     <= 1'b0;
			run_prev_reg        <= 1'b0;
			retry_due           <= 1'b0;
			run_request_virtual <= 1'b0;
		end else begin
			run_prev_reg <= run_sync;
			retry_due    <= 1'b0;
			if (retry_start) begin
				retry_run_reg <= 1'b1;
				retry_cnt_reg <= lin11_ms(retry_interval_reg);
			end else if (retry_run_reg && tick) begin
				if (retry_cnt_reg == 16'h0) begin
					retry_run_reg <= 1'b0;
					retry_due     <= 1'b1;
				end else
					retry_cnt_reg <= retry_cnt_reg - 16'h1;
			end
			if (!run_sync) begin
				restart_run_reg     <= 1'b0;
				run_request_virtual <= 1'b0;
			end else if (!run_prev_reg) begin
				restart_run_reg <= 1'b1;
				restart_cnt_reg <= lin11_ms(restart_delay_reg);
			end else if (restart_run_reg && tick) begin
				if (restart_cnt_reg == 16'h0) begin
					restart_run_reg     <= 1'b0;
					run_request_virtual <= 1'b1;
				end else
					restart_cnt_reg <= restart_cnt_reg - 16'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/psm_bank_asserts.sv ----
// Port checker for the status, telemetry and configuration bank.
`timescale 1ns/1ps
`default_nettype none
module psm_bank_asserts #(
	parameter CHANNELS = 8
) (
	input wire logic                   clk_sys,
	input wire logic                   reset_n,
	input wire logic                   cmd_valid,
	input wire logic                   cmd_write,
	input wire logic [7:0]             cmd_code,
	input wire logic                   cmd_ack,
	input wire logic                   output_ov_fault,
	input wire logic                   output_uv_fault,
	input wire logic                   input_supply_enable_pin,
	input wire logic                   retry_due,
	input wire logic [16*CHANNELS-1:0] channel_config_all,
	input wire logic [7:0]             global_config_out
);
	wire w_d0 = cmd_valid && cmd_write && cmd_code == 8'hD0;
	wire w_d1 = cmd_valid && cmd_write && cmd_code == 8'hD1;
	wire flt = output_ov_fault || output_uv_fault;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_rd;
		cmd_valid && !cmd_write;
	endsequence
	sequence s_wr;
		cmd_valid && cmd_write;
	endsequence
	chk_read_ack: assert property (s_rd |-> ##2 cmd_ack)
		else $error("late read ack");
	chk_write_ack: assert property (s_wr |=> cmd_ack)
		else $error("late write ack");
	chk_ack_cause: assert property (cmd_ack |-> $past(cmd_valid && cmd_write) || $past(cmd_valid && !cmd_write, 2))
		else $error("stray ack");
	chk_global_write: assert property (!$stable(global_config_out) |-> $past(w_d1) || $past(w_d1, 2))
		else $error("global config changed unwritten");
	chk_config_write: assert property (!$stable(channel_config_all) |-> $past(w_d0) || $past(w_d0, 2))
		else $error("channel config changed unwritten");
	chk_enable_held: assert property (!input_supply_enable_pin |=> !input_supply_enable_pin)
		else $error("enable released");
	chk_enable_cause: assert property ($fell(input_supply_enable_pin) |-> $past(flt) || $past(flt, 2))
		else $error("enable dropped without fault");
	chk_retry_pulse: assert property (retry_due |=> !retry_due)
		else $error("long retry pulse");
endmodule
`default_nettype wire

// ---- tb/psm_host_model.sv ----
// Host controller model that issues command reads and writes.
`timescale 1ns/1ps
`default_nettype none
module psm_host_model (
	input  wire logic        clk_sys,
	input  wire logic        cmd_ack,
	input  wire logic [15:0] cmd_rdata,
	output var  logic        cmd_valid = 1'b0,
	output var  logic        cmd_write = 1'b0,
	output var  logic [7:0]  cmd_code = 8'h00,
	output var  logic [15:0] cmd_wdata = 16'h0000
);
	// One valid pulse per command; fields are scrambled after the answer.
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		{cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		while (cmd_ack !== 1'b1 && n < 8) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		q = cmd_ack === 1'b1 ? cmd_rdata : 16'hXXXX;
		{cmd_write, cmd_code, cmd_wdata} = {~w, ~c, ~d};
	endtask
endmodule
`default_nettype wire

// ---- tb/psm_bank_tb.sv ----
// Self-checking bench for the status, telemetry and configuration bank.
`timescale 1ns/1ps
`default_nettype none
module psm_bank_tb;
	localparam [7:0] REV = 8'h3C; // Arbitrary revision code.
	logic clk_sys = 0, reset_n = 0, cml_clear = 0, sample_valid = 0, vout_valid = 0, retry_start = 0;
	logic run_request_pin = 0, output_ov_fault = 0, output_uv_fault = 0, watchdog_reset_pin = 1;
	logic [2:0] page = 0, vout_channel = 0;
	logic [7:0] input_fault_flags = 0, temperature_fault_flags = 0, memory_fault_flags = 0, fault_pin_action;
	logic [7:0] channel_faulted_off = 0, channel_power_good = 0, cmd_code, global_config_out;
	logic [63:0] vendor_state_flags = 0;
	logic [15:0] input_voltage_sample = 0, die_temperature_sample = 0, vout_sample = 0;
	logic [15:0] cmd_wdata, cmd_rdata, q, d, pk, tpk, lv, lt, vpk [8], vlast [8];
	logic cmd_valid, cmd_write, cmd_ack, supply_good_pin, input_supply_enable_pin, retry_due, run_request_virtual;
	logic shared_fault_pin_a_oe, shared_fault_pin_b_oe, shared_fault_pin_c_oe, shared_fault_pin_d_oe;
	logic [127:0] channel_config_all;
	logic [3:0] ext = 0;
	logic [31:0] lf = 32'hA3E146DD;
	int err_count = 0, checks = 0, cyc = 0;
	// Open-drain fault lines.
	wire shared_fault_pin_a = ~(ext[0] | shared_fault_pin_a_oe), shared_fault_pin_b = ~(ext[1] | shared_fault_pin_b_oe);
	wire shared_fault_pin_c = ~(ext[2] | shared_fault_pin_c_oe), shared_fault_pin_d = ~(ext[3] | shared_fault_pin_d_oe);
	psm_bank #(.REVISION_CODE(REV), .TICK_CYCLES(4)) i_psm_bank (.*, .cmd_word(1'b0));
	psm_host_model i_psm_host_model (.*);
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			tally_and_finish();
		end
	end
	function logic [15:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[15:0];
	endfunction
	function longint lval(logic [15:0] w);
		return longint'($signed(w[10:0])) <<< (16 + $signed(w[15:11]));
	endfunction
	function logic [15:0] rstv(logic [7:0] c);
		case (c)
			8'hD0: return 16'h0080;
			8'hD1: return 16'h007B;
			8'hDB: return 16'hF320;
			8'hDC: return 16'hFB20;
			default: return 16'h0000;
		endcase
	endfunction
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		i_psm_host_model.xfer(1'b0, c, 16'h0000, q);
		cmp($sformatf("command %h", c), exp, q);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		i_psm_host_model.xfer(1'b1, c, v, q);
	endtask
	task automatic do_reset();
		reset_n = 0;
		tick(16);
		reset_n = 1;
	endtask
	task automatic span(input logic sel, input int want);
		int n;
		n = 0;
		run_request_pin = sel;
		retry_start = !sel;
		tick(1);
		retry_start = 0;
		while ((sel ? run_request_virtual : retry_due) !== 1'b1 && n < 3000) begin
			tick(1);
			n++;
		end
		run_request_pin = 0;
		cmp("delay window", 16'(n >= want - 4 && n <= want + 6), 16'h0001);
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d, comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		do_reset();
		for (int c = 8'hD0; c <= 8'hDC; c++)
			rd(8'(c), rstv(8'(c)));
		span(0, 804);
		span(1, 1604);
		wr(8'hDB, 16'hF804);
		span(0, 12);
		for (int c = 8'hD0; c <= 8'hDC; c++) begin
			d = rnd() & ((c == 8'hD0 || c == 8'hD4 || c >= 8'hDB) ? 16'hFFFF : 16'h00FF);
			wr(8'(c), d);
			rd(8'(c), d);
		end
		{pk, tpk} = {16'h8000, 16'h8000};
		for (int i = 0; i < 24; i++) begin
			{input_voltage_sample, die_temperature_sample, vout_sample} = {rnd(), rnd(), rnd()};
			{sample_valid, vout_valid, vout_channel, lv, lt} = {2'b11, 3'(i), input_voltage_sample, die_temperature_sample};
			pk = lval(lv) > lval(pk) ? lv : pk;
			tpk = lval(lt) > lval(tpk) ? lt : tpk;
			vpk[i % 8] = (i < 8 || vout_sample > vpk[i % 8]) ? vout_sample : vpk[i % 8];
			vlast[i % 8] = vout_sample;
			tick(1);
			{sample_valid, vout_valid} = 2'b00;
			{input_voltage_sample, die_temperature_sample, vout_sample} = ~{lv, lt, vout_sample};
		end
		for (int p = 0; p < 8; p++) begin
			page = 3'(p);
			rd(8'h8B, vlast[p]);
			rd(8'hDD, vpk[p]);
		end
		rd(8'h88, lv);
		rd(8'h8D, lt);
		rd(8'hDE, pk);
		rd(8'hDF, tpk);
		{input_fault_flags, temperature_fault_flags, memory_fault_flags} = {8'(rnd()), 8'(rnd()), 8'(rnd()) & 8'h3F};
		vendor_state_flags = {rnd(), rnd(), rnd(), rnd()};
		page = 3'd6;
		rd(8'h7C, {8'h00, input_fault_flags});
		rd(8'h7D, {8'h00, temperature_fault_flags});
		rd(8'h80, {8'h00, vendor_state_flags[55:48]});
		rd(8'h98, {8'h00, REV});
		rd(8'h7E, {8'h00, memory_fault_flags});
		wr(8'h88, ~lv);
		rd(8'h88, lv);
		rd(8'h00, 16'hFFFF);
		rd(8'h7E, {8'h00, memory_fault_flags | 8'hC0});
		cml_clear = 1;
		tick(1);
		cml_clear = 0;
		rd(8'h7E, {8'h00, memory_fault_flags});
		page = 3'd5;
		wr(8'hD2, 16'h0001);
		channel_faulted_off = 8'h20;
		tick(4);
		cmp("fault drive", 16'h0005, {12'h000, shared_fault_pin_d_oe, shared_fault_pin_c_oe,
			shared_fault_pin_b_oe, shared_fault_pin_a_oe});
		wr(8'hD3, 16'h0001);
		tick(4);
		cmp("fault drive", 16'h000F, {12'h000, shared_fault_pin_d_oe, shared_fault_pin_c_oe,
			shared_fault_pin_b_oe, shared_fault_pin_a_oe});
		channel_faulted_off = 0;
		for (int i = 0; i < 4; i++) begin
			d = rnd() & 16'h00FF;
			wr(8'hD5 + 8'(i), d);
			ext = 4'(1 << i);
			tick(4);
			cmp("fault action", d, {8'h00, fault_pin_action});
			ext = 0;
		end
		wr(8'hD4, 16'h80FF);
		channel_power_good = 8'hFF;
		tick(4);
		cmp("supply good", 16'h0001, 16'(supply_good_pin));
		watchdog_reset_pin = 0;
		tick(4);
		cmp("supply good", 16'h0000, 16'(supply_good_pin));
		wr(8'hD9, 16'h0000);
		wr(8'hDA, 16'h0080);
		output_ov_fault = 1;
		tick(4);
		cmp("input enable", 16'h0001, 16'(input_supply_enable_pin));
		{output_ov_fault, output_uv_fault} = 2'b01;
		tick(4);
		output_uv_fault = 0;
		tick(4);
		cmp("input enable", 16'h0000, 16'(input_supply_enable_pin));
		do_reset();
		wr(8'hD9, 16'h0080);
		output_ov_fault = 1;
		tick(4);
		cmp("input enable", 16'h0000, 16'(input_supply_enable_pin));
		tally_and_finish();
	end
endmodule
bind psm_bank psm_bank_asserts #(.CHANNELS(CHANNELS)) i_psm_bank_asserts (.*);
`default_nettype wire
